/* File: src/assf_status.v */
// What this block does
// - Nine-bit mode: capture ninth bit with byte
// - Eight-bit mode: ninth bit copies bit seven
// - Load transmit ninth bit with data byte
// - Reset keeps both ninth-bit fields
// - Four error enables; reset clears them
// - Transmit-empty flag, set on transfer, reset sets
// - Transmit-complete when empty and nothing sent
// - Receive-full flag on buffer move, two-step clear
// - Idle flag on line quiet, two-step clear
// - Idle armed only after a received character
// - Overrun keeps old data, drops new
// - Overrun cleared only if seen at status read
// - Noise flag with enable and two-step clear
// - Framing flag on zero stop bit
// - Parity flag on parity failure
// - Break sets framing, full; clears ninth bit in nine-bit mode only
// - Break clears via status two; rearms on ones
// - Reception-active on start slot, no interrupt
// - Length control picks nine or eight bits
// - Module disable forces empty and complete high
//
// File holds the status/flag core with an AXI4-Lite slave.
// Assumes receiver and transmitter datapaths drive event strobes
// on clk_sys, and that the remote line arrives on pin_rx.
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`include "assf_defines.vh"
module assf_status
(
    // Clock, reset, enable
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        ce,
    // AXI4-Lite write channels
    input  wire [4:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read channels
    input  wire [4:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Receive datapath events
    input  wire        pin_rx,
    input  wire        rx_char_done,
    input  wire [7:0]  rx_char_low,
    input  wire        rx_char_bit8,
    input  wire        rx_noise,
    input  wire        rx_zero_stop,
    input  wire        rx_parity_bad,
    input  wire        rx_break,
    input  wire        rx_idle_char,
    input  wire        rx_start_zero,
    input  wire        rx_false_start,
    input  wire        rx_enable_rise,
    // Transmit datapath
    input  wire        tx_take,
    input  wire        tx_busy,
    output wire        tx_pending,
    output wire [8:0]  tx_shift_word,
    // Interrupts and mode
    output wire        irq_error,
    output wire        irq_tx,
    output wire        irq_rx,
    output wire        nine_bit_mode
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg  [7:0] ctrl1;
    reg  [7:0] ctrl2;
    reg  [3:0] err_en;
    reg  [7:0] rx_buf;
    reg  [7:0] tx_buf;
    reg        tx_buf_full;
    reg        txe;
    reg        rxf;
    reg        idle;
    reg        ovr;
    reg        noise;
    reg        frame;
    reg        par;
    reg        brk;
    reg        rx_act;
    reg        idle_armed;
    reg        brk_armed;
    reg  [7:0] s1_seen;
    reg        brk_seen;
    wire       rx_line;
    wire       rx_ninth_bit;
    wire       tx_ninth_bit;
    wire       module_enable;
    wire       txc;
    wire       rx_move;
    wire [7:0] stat1;
    wire [7:0] stat2;
    wire [7:0] ctrl3;

    assign module_enable = ctrl1[`ASSF_C1_EN];
    assign nine_bit_mode = ctrl1[`ASSF_C1_NINE];

    assf_sync u_sync
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .pin     (pin_rx),
        .level   (rx_line)
    );

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // One outstanding transaction per direction; fixed one-cycle take
    wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;

    wire [4:0] wa = s_axi_awaddr;
    wire [4:0] ra = s_axi_araddr;
    wire wr_c1 = wr_go & s_axi_wstrb[0] & (wa == `ASSF_OFS_CTRL1);
    wire wr_c2 = wr_go & s_axi_wstrb[0] & (wa == `ASSF_OFS_CTRL2);
    wire wr_c3 = wr_go & s_axi_wstrb[0] & (wa == {1'b0, `ASSF_OFS_CTRL3});
    wire wr_dr = wr_go & s_axi_wstrb[0] & (wa == {1'b0, `ASSF_OFS_DATA});
    wire wr_map = (wa[1:0] == 2'b00) & (wa <= `ASSF_OFS_CTRL2);
    wire rd_map = (ra[1:0] == 2'b00) & (ra <= `ASSF_OFS_CTRL2);
    wire rd_s1 = rd_go & (ra == {1'b0, `ASSF_OFS_STAT1});
    wire rd_s2 = rd_go & (ra == {1'b0, `ASSF_OFS_STAT2});
    wire rd_dr = rd_go & (ra == {1'b0, `ASSF_OFS_DATA});

    reg [7:0] rd_byte;
    always @*
    begin
        case (ra)
            {1'b0, `ASSF_OFS_CTRL3}: rd_byte = ctrl3;
            {1'b0, `ASSF_OFS_STAT1}: rd_byte = stat1;
            {1'b0, `ASSF_OFS_STAT2}: rd_byte = stat2;
            {1'b0, `ASSF_OFS_DATA}:  rd_byte = rx_buf;
            `ASSF_OFS_CTRL1:         rd_byte = ctrl1;
            `ASSF_OFS_CTRL2:         rd_byte = ctrl2;
            default:                 rd_byte = 8'h00;
        endcase
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= 2'b00;
            s_axi_rdata  <= 32'h0000_0000;
        end
        else if (ce)
        begin
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? 2'b00 : 2'b10;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (rd_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= rd_map ? 2'b00 : 2'b10;
                s_axi_rdata  <= {24'h00_0000, rd_byte};
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrl1  <= `ASSF_RST_C1;
            ctrl2  <= `ASSF_RST_C2;
            err_en <= `ASSF_RST_C3EN;
        end
        else if (ce)
        begin
            if (wr_c1)
                ctrl1 <= s_axi_wdata[7:0];
            if (wr_c2)
                ctrl2 <= s_axi_wdata[7:0];
            if (wr_c3)
                err_en <= s_axi_wdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // Ninth bits
    // ------------------------------------------------------------
    // Break in nine-bit mode forces a zero ninth bit
    wire rx8_val = nine_bit_mode ? (rx_char_bit8 & ~rx_break)
                                 : rx_char_low[7];
    assign rx_move = rx_char_done & ~rxf;

    assf_bits u_bits
    (
        .clk_sys      (clk_sys),
        .ce           (ce),
        .rx_load      (rx_move | (rx_break & nine_bit_mode)),
        .rx_value     (rx8_val),
        .tx_load      (wr_c3),
        .tx_value     (s_axi_wdata[`ASSF_C3_TX8]),
        .rx_ninth_bit (rx_ninth_bit),
        .tx_ninth_bit (tx_ninth_bit)
    );

    assign ctrl3 = {rx_ninth_bit, tx_ninth_bit, 2'b00, err_en};
    // Ninth bit rides with the byte in the same transfer
    assign tx_shift_word = {nine_bit_mode & tx_ninth_bit, tx_buf};
    assign tx_pending    = tx_buf_full;

    // ------------------------------------------------------------
    // Flag-clearing arm: status read remembers which flags it saw
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s1_seen  <= 8'h00;
            brk_seen <= 1'b0;
        end
        else if (ce)
        begin
            if (rd_s1)
                s1_seen <= stat1;
            else if (rd_dr | wr_dr)
                s1_seen <= 8'h00;
            if (rd_s2)
                brk_seen <= brk;
            else if (rd_dr)
                brk_seen <= 1'b0;
        end
    end
    wire clr_rx = rd_dr;

    // ------------------------------------------------------------
    // Flags; set wins over a same-cycle clear, except brk_armed, where the clear wins, and idle_armed, where rx_enable_rise wins
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            txe         <= 1'b1;
            tx_buf_full <= 1'b0;
            tx_buf      <= 8'h00;
            rx_buf      <= 8'h00;
            rxf         <= 1'b0;
            idle        <= 1'b0;
            ovr         <= 1'b0;
            noise       <= 1'b0;
            frame       <= 1'b0;
            par         <= 1'b0;
            brk         <= 1'b0;
            rx_act      <= 1'b0;
            idle_armed  <= 1'b0;
            brk_armed   <= 1'b1;
        end
        else if (ce)
        begin
            // Transmit side
            if (wr_dr)
            begin
                tx_buf      <= s_axi_wdata[7:0];
                tx_buf_full <= 1'b1;
            end
            else if (tx_take)
                tx_buf_full <= 1'b0;
            if (!module_enable)
                txe <= 1'b1;
            else if (tx_take)
                txe <= 1'b1;
            else if (wr_dr & s1_seen[`ASSF_S1_TXE])
                txe <= 1'b0;
            // Receive buffer and full flag; overrun drops new data
            if (rx_move)
                rx_buf <= rx_char_low;
            if (rx_move | rx_break)
                rxf <= 1'b1;
            else if (clr_rx & s1_seen[`ASSF_S1_RXF])
                rxf <= 1'b0;
            if (rx_char_done & rxf)
                ovr <= 1'b1;
            else if (clr_rx & s1_seen[`ASSF_S1_OVR])
                ovr <= 1'b0;
            // Idle needs a character since enable or last clear
            if (rx_enable_rise)
                idle_armed <= 1'b0;
            else if (rx_move)
                idle_armed <= 1'b1;
            else if (clr_rx & s1_seen[`ASSF_S1_IDLE])
                idle_armed <= 1'b0;
            if (rx_idle_char & idle_armed)
                idle <= 1'b1;
            else if (clr_rx & s1_seen[`ASSF_S1_IDLE])
                idle <= 1'b0;
            if (rx_noise)
                noise <= 1'b1;
            else if (clr_rx & s1_seen[`ASSF_S1_NOISE])
                noise <= 1'b0;
            if (rx_zero_stop | rx_break)
                frame <= 1'b1;
            else if (clr_rx & s1_seen[`ASSF_S1_FRAME])
                frame <= 1'b0;
            if (rx_parity_bad)
                par <= 1'b1;
            else if (clr_rx & s1_seen[`ASSF_S1_PAR])
                par <= 1'b0;
            // Break rearms only once the line shows a one
            if (rx_break & brk_armed)
            begin
                brk       <= 1'b1;
                brk_armed <= 1'b0;
            end
            else
            begin
                if (clr_rx & brk_seen)
                    brk <= 1'b0;
                if (rx_line & ~brk)
                    brk_armed <= 1'b1;
            end
            if (rx_start_zero)
                rx_act <= 1'b1;
            else if (rx_false_start | rx_idle_char)
                rx_act <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Derived status and interrupts
    // ------------------------------------------------------------
    // Start latency is the transmitter's; the flag drops on queueing
    assign txc = ~module_enable | (txe & ~tx_busy & ~tx_buf_full);
    assign stat1 = {txe, txc, rxf, idle, ovr, noise, frame, par};
    assign stat2 = {6'h00, brk, rx_act};

    // Neither break nor reception-active feed any interrupt
    assign irq_error = |({ovr, noise, frame, par} & err_en);
    assign irq_tx = module_enable &
                    ((txe & ctrl2[7]) | (txc & ctrl2[6]));
    assign irq_rx = (rxf & ctrl2[5]) | (idle & ctrl2[4]);
endmodule // assf_status

/* File: src/assf_defines.vh */
// Constants for the serial status and flag block
// Assumes inclusion by bare name from src/ design files
`ifndef ASSF_DEFINES_VH
`define ASSF_DEFINES_VH
// Register byte addresses on the AXI4-Lite slave
`define ASSF_OFS_CTRL3      4'h0
`define ASSF_OFS_STAT1      4'h4
`define ASSF_OFS_STAT2      4'h8
`define ASSF_OFS_DATA       4'hc
`define ASSF_OFS_CTRL1      5'h10
`define ASSF_OFS_CTRL2      5'h14
// Control 3 field positions
`define ASSF_C3_RX8         7
`define ASSF_C3_TX8         6
`define ASSF_C3_OVR_IE      3
`define ASSF_C3_NOISE_IE    2
`define ASSF_C3_FRAME_IE    1
`define ASSF_C3_PAR_IE      0
// Status 1 field positions
`define ASSF_S1_TXE         7
`define ASSF_S1_TXC         6
`define ASSF_S1_RXF         5
`define ASSF_S1_IDLE        4
`define ASSF_S1_OVR         3
`define ASSF_S1_NOISE       2
`define ASSF_S1_FRAME       1
`define ASSF_S1_PAR         0
// Status 2 and control 1 field positions
`define ASSF_S2_BRK         1
`define ASSF_S2_RXACT       0
`define ASSF_C1_EN          6
`define ASSF_C1_NINE        4
// Reset values
`define ASSF_RST_C3EN       4'h0
`define ASSF_RST_C2         8'h00
`define ASSF_RST_C1         8'h00
// Transmit start latency, in tenths of a transmitter clock
`define ASSF_TX_LAT_TENTHS  15
`endif

/* File: src/assf_sync.v */
// Three-stage synchroniser for a pin input
// Assumes the pin is asynchronous to clk_sys
module assf_sync
(
    // Clock, reset, enable
    input  wire clk_sys,
    input  wire rst,
    input  wire ce,
    // Pin and result
    input  wire pin,
    output reg  level
);
    reg s1;
    reg s2;
    reg s3;
    // A change counts once stages two and three agree
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s1    <= 1'b1;
            s2    <= 1'b1;
            s3    <= 1'b1;
            level <= 1'b1;
        end
        else if (ce)
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                level <= s3;
        end
    end
endmodule // assf_sync

/* File: src/assf_bits.v */
// Ninth-bit holding flops, untouched by reset
// Assumes load strobes are on clk_sys
module assf_bits
(
    // Clock, enable
    input  wire clk_sys,
    input  wire ce,
    // Received ninth bit
    input  wire rx_load,
    input  wire rx_value,
    // Transmit ninth bit
    input  wire tx_load,
    input  wire tx_value,
    output reg  rx_ninth_bit,
    output reg  tx_ninth_bit
);
    // No reset branch: values survive reset
    always @(posedge clk_sys)
    begin
        if (ce)
        begin
            if (rx_load)
                rx_ninth_bit <= rx_value;
            if (tx_load)
                tx_ninth_bit <= tx_value;
        end
    end
endmodule // assf_bits

/* File: tb/assf_status_asserts.sv */
// Concurrent checks on the status block's bus and transmit ports
// Assumes binding to assf_status, clk_sys and active-high rst
module assf_status_chk
(
    // Clock and reset
    input wire        clk_sys,
    input wire        rst,
    // Bus
    input wire [4:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0]  s_axi_wstrb,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire [4:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    // Transmit and mode
    input wire        tx_take,
    input wire        tx_pending,
    input wire [8:0]  tx_shift_word,
    input wire        nine_bit_mode
);
    wire wst = s_axi_awvalid & s_axi_awready & s_axi_wvalid
             & s_axi_wready & s_axi_wstrb[0];
    wire rtk = s_axi_arvalid & s_axi_arready;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    a_write_answer:
        assert property (wst |=> s_axi_bvalid) else $error("no bvalid");
    a_read_answer:
        assert property (rtk |=> s_axi_rvalid) else $error("no rvalid");
    a_write_refused:
        assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken during response");
    a_read_upper:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unmapped_err:
        assert property (rtk && s_axi_araddr >= 5'h18
            |=> s_axi_rresp == 2'b10) else $error("unmapped not refused");

    // ------------------------------------------------------------
    // Transmit buffer and mode
    // ------------------------------------------------------------
    a_mode_follow:
        assert property (wst && s_axi_awaddr == 5'h10
            |=> nine_bit_mode == $past(s_axi_wdata[4]))
        else $error("mode bit wrong");
    a_tx_load:
        assert property (wst && s_axi_awaddr == 5'h0c |=> tx_pending
            && tx_shift_word[7:0] == $past(s_axi_wdata[7:0]))
        else $error("buffer write lost");
    a_byte_steady:
        assert property (tx_pending && !wst
            |=> $stable(tx_shift_word[7:0])) else $error("byte moved");
    a_take_empties:
        assert property (tx_take && !wst |=> !tx_pending)
        else $error("buffer still full after take");
endmodule // assf_status_chk

bind assf_status assf_status_chk assf_status_chk_inst
(
    .clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .tx_take, .tx_pending,
    .tx_shift_word, .nine_bit_mode
);

/* File: tb/assf_peer.sv */
// Stand-in for the remote line and the receive/transmit datapaths
// Assumes the bench raises go for one clk_sys cycle per event
module assf_peer
(
    // Clock and command
    input  wire       clk_sys,
    input  wire       go,
    input  wire [3:0] cmd,
    input  wire [7:0] byte_in,
    input  wire       bit8_in,
    // Line and receive events
    output reg        pin_rx = 1'b1,
    output wire       rx_char_done,
    output reg  [7:0] rx_char_low = 8'h00,
    output reg        rx_char_bit8 = 1'b0,
    output wire       rx_noise,
    output wire       rx_zero_stop,
    output wire       rx_parity_bad,
    output wire       rx_break,
    output wire       rx_idle_char,
    output wire       rx_start_zero,
    output wire       rx_false_start,
    output wire       rx_enable_rise,
    // Transmit side
    output wire       tx_take,
    output reg        tx_busy = 1'b0
);
    reg [9:0] ev = 10'h000;

    assign {tx_take, rx_enable_rise, rx_false_start, rx_start_zero,
            rx_idle_char, rx_break, rx_parity_bad, rx_zero_stop,
            rx_noise, rx_char_done} = ev;

    // Break holds the line low until ones are commanded
    always @(posedge clk_sys)
    begin
        ev <= go ? (10'h001 << cmd) : 10'h000;
        if (go)
        begin
            rx_char_low  <= byte_in;
            rx_char_bit8 <= bit8_in;
            if (cmd == 4'h4) pin_rx <= 1'b0;
            if (cmd == 4'hc) pin_rx <= 1'b1;
            if (cmd == 4'ha) tx_busy <= 1'b1;
            if (cmd == 4'hb) tx_busy <= 1'b0;
        end
    end
endmodule // assf_peer

/* File: tb/assf_status_tb.sv */
// Self-checking bench for the serial status and flag block
// Assumes design files, checker and assf_peer are compiled first
`include "assf_defines.vh"
module assf_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [4:0] C3 = `ASSF_OFS_CTRL3, S1 = `ASSF_OFS_STAT1,
        S2 = `ASSF_OFS_STAT2, DR = `ASSF_OFS_DATA, C1 = `ASSF_OFS_CTRL1,
        C2 = `ASSF_OFS_CTRL2;
    localparam [3:0] CH = 0, NZ = 1, BK = 4, ID = 5, SZ = 6, FS = 7,
        ER = 8, TK = 9, BON = 10, BOF = 11, ONE = 12;
    logic clk_sys = 0, rst = 1, go = 0, bit8_in = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [3:0] cmd = 0, s_axi_wstrb = 4'hf;
    logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [7:0] byte_in = 0;
    logic [31:0] s_axi_wdata = 0, rdv;
    logic [1:0] rrs, brs;
    wire [31:0] s_axi_rdata;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [8:0] tx_shift_word;
    wire [7:0] rx_char_low;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, pin_rx, rx_char_done, rx_char_bit8, rx_noise;
    wire rx_zero_stop, rx_parity_bad, rx_break, rx_idle_char;
    wire rx_start_zero, rx_false_start, rx_enable_rise, tx_take;
    wire tx_busy, tx_pending, irq_error, irq_tx, irq_rx, nine_bit_mode;
    int error_cnt = 0;
    int cmp_count = 0;

    assf_status assf_status_inst
    (
        .clk_sys, .rst, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_rx,
        .rx_char_done, .rx_char_low, .rx_char_bit8, .rx_noise,
        .rx_zero_stop, .rx_parity_bad, .rx_break, .rx_idle_char,
        .rx_start_zero, .rx_false_start, .rx_enable_rise, .tx_take,
        .tx_busy, .tx_pending, .tx_shift_word, .irq_error, .irq_tx,
        .irq_rx, .nine_bit_mode
    );
    assf_peer assf_peer_inst
    (
        .clk_sys, .go, .cmd, .byte_in, .bit8_in, .pin_rx, .rx_char_done,
        .rx_char_low, .rx_char_bit8, .rx_noise, .rx_zero_stop,
        .rx_parity_bad, .rx_break, .rx_idle_char, .rx_start_zero,
        .rx_false_start, .rx_enable_rise, .tx_take, .tx_busy
    );

    initial forever #5 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Bus, event and compare helpers
    // ------------------------------------------------------------
    task chk(input [31:0] s, input [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            error_cnt++;
            $display("ERROR %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task wr(input [4:0] a, input [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge clk_sys); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        brs = s_axi_bresp;
    endtask
    task rd(input [4:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rdv = s_axi_rdata;
        rrs = s_axi_rresp;
    endtask
    task rc(input [4:0] a, input [7:0] e);
        rd(a);
        chk(rdv, {24'h0, e});
    endtask
    task clr;
        rd(S1);
        rd(DR);
    endtask
    // Flags land one edge after the strobe, so wait it out
    task ev(input [3:0] c, input [7:0] d = 8'h00, input b = 1'b0);
        cmd <= c;
        byte_in <= d;
        bit8_in <= b;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        rc(S1, 8'hc0);
        rd(C3);
        chk(rdv[3:0], 4'h0);
        rc(S2, 8'h00);
        rc(C1, 8'h00);
        rd(5'h18);
        chk(rrs, 2'b10);
        wr(5'h18, 8'h00);
        chk(brs, 2'b10);
    endtask
    task t_rx9;
        wr(C1, 8'h50);
        ev(CH, 8'h3c, 1'b1);
        rd(C3);
        chk(rdv[7], 1'b1);
        rc(S1, 8'he0);
        rc(DR, 8'h3c);
        rc(S1, 8'hc0);
        wr(C1, 8'h40);
        ev(CH, 8'h81, 1'b0);
        rd(C3);
        chk(rdv[7], 1'b1);
        clr;
        ev(CH, 8'h01, 1'b1);
        rd(C3);
        chk(rdv[7], 1'b0);
        clr;
    endtask
    task t_ovr;
        ev(CH, 8'h11);
        ev(CH, 8'h22);
        rc(S1, 8'he8);
        wr(C3, 8'h08);
        chk(irq_error, 1);
        rc(DR, 8'h11);
        rc(S1, 8'hc0);
        ev(CH, 8'h33);
        rd(S1);
        ev(CH, 8'h44);
        rc(DR, 8'h33);
        rc(S1, 8'hc8);
        rd(DR);
        rc(S1, 8'hc0);
        chk(irq_error, 0);
    endtask
    task t_err;
        for (int i = 0; i < 3; i++)
        begin
            wr(C3, 8'h00);
            ev(NZ + i[3:0]);
            chk(irq_error, 0);
            wr(C3, 8'h04 >> i);
            chk(irq_error, 1);
            rd(DR);
            rc(S1, 8'hc0 | (8'h04 >> i));
            rd(DR);
            rc(S1, 8'hc0);
            chk(irq_error, 0);
        end
    endtask
    task t_brk;
        wr(C3, 8'h00);
        wr(C1, 8'h50);
        ev(CH, 8'h00, 1'b1);
        clr;
        ev(BK);
        rd(C3);
        chk(rdv[7], 1'b0);
        rc(S1, 8'he2);
        rc(S2, 8'h02);
        rd(DR);
        rc(S2, 8'h00);
        clr;
        ev(BK);
        rc(S2, 8'h00);
        clr;
        ev(ONE);
        // Line must read high through the synchroniser before rearm
        repeat (4) @(posedge clk_sys);
        ev(BK);
        rc(S2, 8'h02);
        rd(DR);
        clr;
        ev(ONE);
    endtask
    task t_idle;
        wr(C1, 8'h40);
        ev(ER);
        ev(ID);
        rc(S1, 8'hc0);
        wr(C2, 8'h10);
        ev(SZ);
        rc(S2, 8'h01);
        ev(FS);
        rc(S2, 8'h00);
        ev(CH, 8'h55);
        ev(SZ);
        ev(ID);
        rc(S1, 8'hf0);
        chk(irq_rx, 1);
        rc(S2, 8'h00);
        rc(DR, 8'h55);
        rc(S1, 8'hc0);
        chk(irq_rx, 0);
        ev(ID);
        rc(S1, 8'hc0);
    endtask
    task t_tx;
        wr(C3, 8'h40);
        wr(C1, 8'h50);
        chk(nine_bit_mode, 1);
        wr(C2, 8'hc0);
        chk(irq_tx, 1);
        rd(S1);
        wr(DR, 8'ha5);
        chk(tx_pending, 1);
        rc(S1, 8'h00);
        chk(tx_shift_word, 9'h1a5);
        chk(irq_tx, 0);
        ev(TK);
        chk(tx_pending, 0);
        rc(S1, 8'hc0);
        ev(BON);
        rc(S1, 8'h80);
        ev(BOF);
        rc(S1, 8'hc0);
        rd(S1);
        wr(DR, 8'h5a);
        wr(C1, 8'h00);
        rc(S1, 8'hc0);
        chk(irq_tx, 0);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rd(C3);
        chk(rdv[7:6], 2'b01);
    endtask

    task end_of_test;
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset;
        t_rx9;
        t_ovr;
        t_err;
        t_brk;
        t_idle;
        t_tx;
        end_of_test;
    end

    // Whole run needs a few hundred cycles; this is ample
    initial
    begin
        #200000;
        error_cnt++;
        end_of_test;
    end
endmodule // assf_status_tb
